// >>> hdl/anxnp_regs.sv
// Expansion status and next-page transmit registers of the negotiation.
//
// Behaviour
// [R1] Reserved expansion status bits always read zero.
// [R2] Manager writes reserved bits with their defaults.
// [R3] Gated reserved bits take writes only under override.
// [R4] Parallel detection fault sets a sticky flag.
// [R5] Partner next-page bit sets partner capable flag.
// [R6] Local next-page capable flag reads one.
// [R7] Each stored received page sets sticky flag.
// [R8] Reading expansion status clears page received.
// [R9] Partner negotiation capable set by valid bursts.
// [R10] Next-page transmit word lives at address seven.
// [R11] Sent more-pages bit follows the stored bit.
// [R12] Next pages need more-pages and capable partner.
// [R13] Sent message-page bit follows the stored bit.
// [R14] Sent comply bit follows the stored bit.
// [R15] Toggle inverts after each sent next page.
// [R16] First toggle is inverse of base bit eleven.
// [R17] Eleven code bits fill the sent code field.
// [R18] Sticky flags hold until read, then track.
// [R19] Writes to read-only status and toggle ignored.
`timescale 1ns/1ps
`default_nettype none

module anxnp_regs #(
    parameter logic LOCAL_NP_ABLE = 1'b1
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic mgmt_rd_stb,
    input wire logic mgmt_wr_stb,
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rd_valid,
    output logic mgmt_rd_hit,
    input wire logic cmd_override_we,
    output logic [10:0] exp_aux_bits,
    input wire logic an_restart,
    input wire logic flp_burst_valid,
    input wire logic pd_fault_cond,
    input wire logic rx_page_stored,
    input wire logic rx_np_bit,
    input wire logic base_page_sent,
    input wire logic base_bit11,
    input wire logic np_word_sent,
    output logic [15:0] np_tx_word,
    output logic np_tx_allowed,
    output logic np_word_ready,
    output logic np_phase_active
);

    // ====================
    // Access decode
    // ====================
    logic rd_exp;
    logic wr_exp;
    logic wr_np;

    // Strobes qualified by the addressed register.
    assign rd_exp = mgmt_rd_stb && (mgmt_addr == anxnp_pkg::ADDR_EXP_STATUS);
    assign wr_exp = mgmt_wr_stb && (mgmt_addr == anxnp_pkg::ADDR_EXP_STATUS);
    assign wr_np = mgmt_wr_stb && (mgmt_addr == anxnp_pkg::ADDR_NP_TX);

    // ====================
    // Latching-high status flags
    // ====================
    logic [anxnp_pkg::STICKY_COUNT-1:0] sticky_set;
    logic [anxnp_pkg::STICKY_COUNT-1:0] sticky_flag;

    // Fault is a level condition; a stored page is a one-cycle event.
    assign sticky_set[anxnp_pkg::STICKY_PD_FAULT] = pd_fault_cond; // [R4]
    assign sticky_set[anxnp_pkg::STICKY_PAGE_RX] = rx_page_stored; // [R7]

    // One flag cell per latching bit, each cleared by an expansion read.
    genvar gi;
    generate
        for (gi = 0; gi < anxnp_pkg::STICKY_COUNT; gi = gi + 1) begin : g_lh
            anxnp_sticky_flag u_flag (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .set_cond(sticky_set[gi]),
                .read_clr(rd_exp), // [R8]
                .flag(sticky_flag[gi])
            );
        end
    endgenerate

    // ====================
    // Partner capability flags
    // ====================
    logic lp_an_able_r;
    logic lp_np_able_r;

    // Zero until a valid burst; a restart forgets the partner.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lp_an_able_r <= 1'b0;
        end else if (flp_burst_valid) begin
            lp_an_able_r <= 1'b1; // [R9]
        end else if (an_restart) begin
            lp_an_able_r <= 1'b0;
        end
    end

    // Partner next-page capable: set when a stored page has its
    // next-page bit set, cleared only by restart or reset.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lp_np_able_r <= 1'b0;
        end else if (rx_page_stored && rx_np_bit) begin
            lp_np_able_r <= 1'b1; // [R5]
        end else if (an_restart) begin
            lp_np_able_r <= 1'b0;
        end
    end

    // ====================
    // Override-gated reserved bits of the expansion register
    // ====================
    logic [anxnp_pkg::EXP_RSV_W-1:0] exp_aux_r;

    // These bits steer hidden auxiliary functions. They are stored only
    // while the override enable is high and are never shown on reads.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            exp_aux_r <= anxnp_pkg::EXP_RSV_RESET;
        end else if (wr_exp && cmd_override_we) begin
            exp_aux_r <= mgmt_wdata[anxnp_pkg::EXP_RSV_MSB:
                                    anxnp_pkg::EXP_RSV_LSB]; // [R3]
        end
    end

    assign exp_aux_bits = exp_aux_r;

    // ====================
    // Next-page transmit word storage
    // ====================
    logic more_pages_flag_r;
    logic message_page_flag_r;
    logic comply_ack_flag_r;
    logic [anxnp_pkg::NP_CODE_W-1:0] np_code_r;

    // Writable fields; reserved bit 14 and the toggle bit are dropped.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            more_pages_flag_r <=
                anxnp_pkg::NP_TX_RESET[anxnp_pkg::NP_MORE_BIT];
            message_page_flag_r <=
                anxnp_pkg::NP_TX_RESET[anxnp_pkg::NP_MSG_BIT];
            comply_ack_flag_r <=
                anxnp_pkg::NP_TX_RESET[anxnp_pkg::NP_COMPLY_ACK_FLAG_BIT];
            np_code_r <= anxnp_pkg::NP_TX_RESET[anxnp_pkg::NP_CODE_MSB:0];
        end else if (wr_np) begin
            more_pages_flag_r <= mgmt_wdata[anxnp_pkg::NP_MORE_BIT];
            message_page_flag_r <= mgmt_wdata[anxnp_pkg::NP_MSG_BIT];
            comply_ack_flag_r <= mgmt_wdata[anxnp_pkg::NP_COMPLY_ACK_FLAG_BIT];
            np_code_r <= mgmt_wdata[anxnp_pkg::NP_CODE_MSB:0];
        end
    end

    // ====================
    // Next-page exchange phase
    // ====================
    anxnp_pkg::anxnp_state_t state_r;
    anxnp_pkg::anxnp_state_t state_nxt;
    logic np_allowed_nxt;
    logic np_sent_ok;

    // Next pages are permitted only when both ends want them.
    assign np_allowed_nxt = more_pages_flag_r & lp_np_able_r; // [R12]

    // A next-page send report counts only inside the next-page phase.
    assign np_sent_ok = np_word_sent &&
                        (state_r == anxnp_pkg::ANXNP_ST_NEXT);

    // Phase sequence: base page out, then next pages while allowed,
    // until a page that announces itself as the last one is sent.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            anxnp_pkg::ANXNP_ST_IDLE: begin
                if (base_page_sent) begin
                    state_nxt = anxnp_pkg::ANXNP_ST_BASE;
                end
            end
            anxnp_pkg::ANXNP_ST_BASE: begin
                if (np_allowed_nxt) begin
                    state_nxt = anxnp_pkg::ANXNP_ST_NEXT;
                end
            end
            anxnp_pkg::ANXNP_ST_NEXT: begin
                if (np_word_sent && !more_pages_flag_r) begin
                    state_nxt = anxnp_pkg::ANXNP_ST_DONE;
                end
            end
            anxnp_pkg::ANXNP_ST_DONE: begin
                state_nxt = anxnp_pkg::ANXNP_ST_DONE;
            end
            default: begin
                state_nxt = anxnp_pkg::ANXNP_ST_IDLE;
            end
        endcase
        if (an_restart) begin
            state_nxt = anxnp_pkg::ANXNP_ST_IDLE;
        end
    end

    // Phase register.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= anxnp_pkg::ANXNP_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ====================
    // Toggle bit
    // ====================
    logic toggle_r;

    // Seeded from the sent base word, inverted per sent next page;
    // management writes never reach it.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            toggle_r <= anxnp_pkg::BASE_TOGGLE_RESET;
        end else if (base_page_sent &&
                     (state_r == anxnp_pkg::ANXNP_ST_IDLE)) begin
            toggle_r <= ~base_bit11; // [R16]
        end else if (np_sent_ok) begin
            toggle_r <= ~toggle_r; // [R15]
        end
    end

    // ====================
    // Page loaded indication
    // ====================
    logic np_ready_r;

    // Set by a page write, cleared once sent; a write in the send
    // cycle wins so the new page is not lost.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            np_ready_r <= 1'b0;
        end else if (wr_np) begin
            np_ready_r <= 1'b1;
        end else if (np_sent_ok || an_restart) begin
            np_ready_r <= 1'b0;
        end
    end

    // ====================
    // Outgoing next-page code word
    // ====================
    logic [15:0] np_word_nxt;
    logic [15:0] np_tx_word_r;
    logic np_tx_allowed_r;

    // Code word assembled from the stored fields and the toggle.
    always_comb begin
        np_word_nxt = 16'h0000;
        np_word_nxt[anxnp_pkg::NP_MORE_BIT] = more_pages_flag_r; // [R11]
        np_word_nxt[anxnp_pkg::NP_MSG_BIT] = message_page_flag_r; // [R13]
        np_word_nxt[anxnp_pkg::NP_COMPLY_ACK_FLAG_BIT] = comply_ack_flag_r; // [R14]
        np_word_nxt[anxnp_pkg::NP_TOGGLE_BIT] = toggle_r;
        np_word_nxt[anxnp_pkg::NP_CODE_MSB:0] = np_code_r; // [R17]
    end

    // Transmit-side outputs come from flip-flops, one cycle behind.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            np_tx_word_r <= 16'h0000;
            np_tx_allowed_r <= 1'b0;
        end else begin
            np_tx_word_r <= np_word_nxt;
            np_tx_allowed_r <= np_allowed_nxt;
        end
    end

    assign np_tx_word = np_tx_word_r;
    assign np_tx_allowed = np_tx_allowed_r;
    assign np_word_ready = np_ready_r;
    assign np_phase_active = (state_r == anxnp_pkg::ANXNP_ST_NEXT);

    // ====================
    // Read path
    // ====================
    logic [15:0] exp_view;
    logic [15:0] rdata_nxt;
    logic hit_nxt;
    logic [15:0] rdata_r;
    logic rd_valid_r;
    logic rd_hit_r;

    // Expansion view: reserved bits forced low, status bits live.
    // Writes to this address change none of these bits.
    always_comb begin
        exp_view = 16'h0000; // [R1] [R19]
        exp_view[anxnp_pkg::EXP_PD_FAULT_BIT] =
            sticky_flag[anxnp_pkg::STICKY_PD_FAULT];
        exp_view[anxnp_pkg::EXP_LP_NP_ABLE_BIT] = lp_np_able_r;
        exp_view[anxnp_pkg::EXP_NP_ABLE_BIT] = LOCAL_NP_ABLE; // [R6]
        exp_view[anxnp_pkg::EXP_PAGE_RX_BIT] =
            sticky_flag[anxnp_pkg::STICKY_PAGE_RX];
        exp_view[anxnp_pkg::EXP_LP_AN_ABLE_BIT] = lp_an_able_r;
    end

    // Read multiplexer; other addresses answer zero with no hit.
    always_comb begin
        rdata_nxt = 16'h0000;
        hit_nxt = 1'b0;
        case (mgmt_addr)
            anxnp_pkg::ADDR_EXP_STATUS: begin
                rdata_nxt = exp_view;
                hit_nxt = 1'b1;
            end
            anxnp_pkg::ADDR_NP_TX: begin // [R10]
                rdata_nxt = np_word_nxt; // reserved bit 14 stays zero
                hit_nxt = 1'b1;
            end
            default: begin
                rdata_nxt = 16'h0000;
                hit_nxt = 1'b0;
            end
        endcase
    end

    // Read data are captured on the read strobe and held until the
    // next read; valid pulses for one cycle.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 16'h0000;
            rd_hit_r <= 1'b0;
        end else if (mgmt_rd_stb) begin
            rdata_r <= rdata_nxt;
            rd_hit_r <= hit_nxt;
        end
    end

    // Read valid pulse.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= mgmt_rd_stb;
        end
    end

    assign mgmt_rdata = rdata_r;
    assign mgmt_rd_valid = rd_valid_r;
    assign mgmt_rd_hit = rd_hit_r;

endmodule
`default_nettype wire

// >>> hdl/anxnp_pkg.sv
// Constants shared by the expansion status and next-page transmit logic.
package anxnp_pkg;

    // ====================
    // Management register addresses
    // ====================
    localparam logic [4:0] ADDR_EXP_STATUS = 5'h06;
    localparam logic [4:0] ADDR_NP_TX = 5'h07;

    // ====================
    // Expansion status field positions
    // ====================
    localparam int EXP_RSV_MSB = 15;
    localparam int EXP_RSV_LSB = 5;
    localparam int EXP_RSV_W = EXP_RSV_MSB - EXP_RSV_LSB + 1;
    localparam int EXP_PD_FAULT_BIT = 4;
    localparam int EXP_LP_NP_ABLE_BIT = 3;
    localparam int EXP_NP_ABLE_BIT = 2;
    localparam int EXP_PAGE_RX_BIT = 1;
    localparam int EXP_LP_AN_ABLE_BIT = 0;
    localparam logic [EXP_RSV_W-1:0] EXP_RSV_RESET = 11'h000;

    // ====================
    // Latching-high flag slots
    // ====================
    localparam int STICKY_COUNT = 2;
    localparam int STICKY_PD_FAULT = 0;
    localparam int STICKY_PAGE_RX = 1;

    // ====================
    // Next-page transmit word field positions and reset value
    // ====================
    localparam int NP_MORE_BIT = 15;
    localparam int NP_RSV_BIT = 14;
    localparam int NP_MSG_BIT = 13;
    localparam int NP_COMPLY_ACK_FLAG_BIT = 12;
    localparam int NP_TOGGLE_BIT = 11;
    localparam int NP_CODE_MSB = 10;
    localparam int NP_CODE_W = NP_CODE_MSB + 1;
    localparam logic [15:0] NP_TX_RESET = 16'h2001;
    localparam logic BASE_TOGGLE_RESET = 1'b0;

    // ====================
    // Next-page exchange phase
    // ====================
    typedef enum logic [3:0] {
        ANXNP_ST_IDLE = 4'h1,
        ANXNP_ST_BASE = 4'h2,
        ANXNP_ST_NEXT = 4'h4,
        ANXNP_ST_DONE = 4'h8
    } anxnp_state_t;

endpackage

// >>> hdl/anxnp_sticky_flag.sv
// Latching-high status flag that holds until the owning register is read.
`timescale 1ns/1ps
`default_nettype none

module anxnp_sticky_flag (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic set_cond,
    input wire logic read_clr,
    output logic flag
);

    // ====================
    // Flag storage
    // ====================
    logic flag_r;
    logic flag_nxt;

    // The condition wins over the read, so an event in the read cycle
    // survives, and a condition still present after the read shows again.
    assign flag_nxt = set_cond | (flag_r & ~read_clr); // [R18]

    // Flag register, cleared by reset.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag = flag_r;

endmodule
`default_nettype wire

// >>> dv/anxnp_regs_asserts.sv
// Concurrent checks on the expansion and next-page register block ports.
`timescale 1ns/1ps
`default_nettype none

module anxnp_regs_chk #(
    parameter logic LOCAL_NP_ABLE = 1'b1
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic mgmt_rd_stb,
    input wire logic mgmt_wr_stb,
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rd_valid,
    input wire logic mgmt_rd_hit,
    input wire logic cmd_override_we,
    input wire logic [10:0] exp_aux_bits,
    input wire logic an_restart,
    input wire logic pd_fault_cond,
    input wire logic rx_page_stored,
    input wire logic rx_np_bit,
    input wire logic base_page_sent,
    input wire logic base_bit11,
    input wire logic np_word_sent,
    input wire logic [15:0] np_tx_word,
    input wire logic np_tx_allowed,
    input wire logic np_phase_active
);
    // ====================
    // Decoded accesses
    // ====================
    logic rd6, rd7, wr6, wr7, tg;
    logic [10:0] wd_hi;
    logic [15:0] wd_np;
    // Register hits, the gated write field and the sent toggle bit.
    assign rd6 = mgmt_rd_stb && mgmt_addr == 5'h06;
    assign rd7 = mgmt_rd_stb && mgmt_addr == 5'h07;
    assign wr6 = mgmt_wr_stb && mgmt_addr == 5'h06;
    assign wr7 = mgmt_wr_stb && mgmt_addr == 5'h07;
    assign wd_hi = mgmt_wdata[15:5];
    assign wd_np = mgmt_wdata & 16'hB7FF;
    assign tg = np_tx_word[11];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // A status read two cycles after an event, with no read between.
    sequence gap_rd6;
        !mgmt_rd_stb ##1 rd6;
    endsequence

    // ====================
    // Assertions
    // ====================
    // Read data, flags and the sent word tied to their causes.
    rsv_zero_a: assert property (
        rd6 |=> mgmt_rd_valid && mgmt_rd_hit && mgmt_rdata[15:5] == 11'h000
        && mgmt_rdata[2] == LOCAL_NP_ABLE)
        else $error("status read shows wrong fixed bits");
    np_addr_a: assert property (
        rd7 |=> mgmt_rd_valid && mgmt_rd_hit && !mgmt_rdata[14])
        else $error("next-page word read is wrong");
    gate_off_a: assert property (
        wr6 && !cmd_override_we |=> $stable(exp_aux_bits))
        else $error("gated bits changed without override");
    gate_on_a: assert property (
        wr6 && cmd_override_we |=> exp_aux_bits == $past(wd_hi))
        else $error("gated bits ignored an override write");
    sticky_pd_a: assert property (
        pd_fault_cond ##1 gap_rd6 |=> mgmt_rdata[4])
        else $error("fault flag not latched");
    lp_np_a: assert property (
        rx_page_stored && rx_np_bit ##1 gap_rd6 |=> mgmt_rdata[3])
        else $error("partner next-page flag not set");
    page_set_a: assert property (
        rx_page_stored ##1 gap_rd6 |=> mgmt_rdata[1])
        else $error("page received flag not latched");
    page_clr_a: assert property (
        rd6 && !rx_page_stored ##1 !rx_page_stored && !mgmt_rd_stb
        ##1 rd6 && !rx_page_stored |=> !mgmt_rdata[1])
        else $error("page received flag not cleared by read");
    np_fields_a: assert property (
        wr7 ##1 !mgmt_wr_stb |=> (np_tx_word & 16'hF7FF) == $past(wd_np, 2))
        else $error("sent word fields do not follow the write");
    toggle_inv_a: assert property (
        !np_word_sent ##1 np_phase_active && np_word_sent && !an_restart
        ##1 !np_word_sent |=> tg != $past(tg, 2))
        else $error("toggle did not invert after a sent page");
    toggle_init_a: assert property (
        base_page_sent && !np_phase_active && !an_restart
        |-> ##2 tg == !$past(base_bit11, 2))
        else $error("first toggle is not inverse of base bit");
    np_gate_a: assert property (
        $rose(np_phase_active) |-> np_tx_allowed)
        else $error("next-page phase entered while not allowed");

    // Main scenarios reached.
    cover property (rd6 ##1 mgmt_rd_valid);
    cover property (wr6 && cmd_override_we);
    cover property ($rose(np_phase_active));
endmodule
`default_nettype wire

// >>> dv/anxnp_sta_model.sv
// Station manager model driving the management register port.
`timescale 1ns/1ps
`default_nettype none

module anxnp_sta_model (
    input wire logic core_clk,
    output logic mgmt_rd_stb,
    output logic mgmt_wr_stb,
    output logic [4:0] mgmt_addr,
    output logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rd_valid
);
    // ====================
    // Transfers
    // ====================
    // Strobes start low so no request precedes the reset release.
    initial begin
        mgmt_rd_stb = 1'b0;
        mgmt_wr_stb = 1'b0;
        mgmt_addr = 5'h00;
        mgmt_wdata = 16'h0000;
    end

    // One write; reserved bits keep their defaults unless raw is set.
    task automatic wr(input logic [4:0] a, input logic [15:0] d,
                      input logic raw);
        logic [15:0] v;
        v = d;
        if (!raw && a == 5'h07) begin
            v[14] = 1'b0;
        end
        if (!raw && a == 5'h06) begin
            v[15:5] = 11'h000;
        end
        @(posedge core_clk);
        #1;
        mgmt_wr_stb = 1'b1;
        mgmt_addr = a;
        mgmt_wdata = v;
        @(posedge core_clk);
        #1;
        mgmt_wr_stb = 1'b0;
        mgmt_addr = ~a;
        mgmt_wdata = ~v;
    endtask

    // One read; the word is taken in the cycle flagged valid.
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge core_clk);
        #1;
        mgmt_rd_stb = 1'b1;
        mgmt_addr = a;
        @(posedge core_clk);
        #1;
        mgmt_rd_stb = 1'b0;
        mgmt_addr = ~a;
        d = (mgmt_rd_valid === 1'b1) ? mgmt_rdata : ~mgmt_rdata;
    endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the expansion and next-page register block.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic core_clk, reset_n, mgmt_rd_stb, mgmt_wr_stb, mgmt_rd_valid;
    logic mgmt_rd_hit, cmd_override_we, an_restart, flp_burst_valid;
    logic pd_fault_cond, rx_page_stored, rx_np_bit, base_page_sent;
    logic base_bit11, np_word_sent, np_tx_allowed, np_word_ready;
    logic np_phase_active, tgl;
    logic [4:0] mgmt_addr;
    logic [15:0] mgmt_wdata, mgmt_rdata, np_tx_word;
    logic [10:0] exp_aux_bits;
    logic [5:0] evs;
    int errors, checks;

    // ====================
    // Clock, events and instances
    // ====================
    // Free-running clock of 50 ns period.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Link event inputs come from one vector.
    assign {an_restart, flp_burst_valid, pd_fault_cond, rx_page_stored,
            base_page_sent, np_word_sent} = evs;

    anxnp_regs #(.LOCAL_NP_ABLE(1'b1)) uut (
        .core_clk, .reset_n, .mgmt_rd_stb, .mgmt_wr_stb, .mgmt_addr,
        .mgmt_wdata, .mgmt_rdata, .mgmt_rd_valid, .mgmt_rd_hit,
        .cmd_override_we, .exp_aux_bits, .an_restart, .flp_burst_valid,
        .pd_fault_cond, .rx_page_stored, .rx_np_bit, .base_page_sent,
        .base_bit11, .np_word_sent, .np_tx_word, .np_tx_allowed,
        .np_word_ready, .np_phase_active
    );

    anxnp_sta_model sta (
        .core_clk, .mgmt_rd_stb, .mgmt_wr_stb, .mgmt_addr, .mgmt_wdata,
        .mgmt_rdata, .mgmt_rd_valid
    );

    // ====================
    // Shared tasks
    // ====================
    // Compares one value and counts it.
    task automatic chk(input string n, input logic [15:0] s,
                       input logic [15:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    // Reads one register and compares the word.
    task automatic rc(input logic [4:0] a, input logic [15:0] e,
                      input string n);
        logic [15:0] d;
        sta.rd(a, d);
        chk(n, d, e);
    endtask

    // Pulses the selected link events for one cycle.
    task automatic ev(input logic [5:0] m);
        @(posedge core_clk);
        #1;
        evs = m;
        @(posedge core_clk);
        #1;
        evs = 6'h00;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ====================
    // Scenarios
    // ====================
    // Values after reset and a read of an unmapped address.
    task automatic t_reset();
        rc(5'h06, 16'h0004, "status reset");
        rc(5'h07, 16'h2001, "np reset");
        rc(5'h1F, 16'h0000, "unmapped");
        chk("unmapped hit", {15'h0000, mgmt_rd_hit}, 16'h0000);
    endtask

    // Gated reserved bits locked, then opened by the override.
    task automatic t_rsv();
        sta.wr(5'h06, 16'hFFFF, 1'b1);
        chk("aux locked", {5'h00, exp_aux_bits}, 16'h0000);
        rc(5'h06, 16'h0004, "status ro");
        cmd_override_we = 1'b1;
        sta.wr(5'h06, 16'hABC0, 1'b1);
        chk("aux open", {5'h00, exp_aux_bits}, 16'h055E);
        cmd_override_we = 1'b0;
        rc(5'h06, 16'h0004, "status rsv");
    endtask

    // Sticky and partner flags: set, clear on read, hold, restart.
    task automatic t_flags();
        rx_np_bit = 1'b1;
        ev(6'h1C);
        rc(5'h06, 16'h001F, "flags set");
        rc(5'h06, 16'h000D, "flags read");
        evs = 6'h08;
        rc(5'h06, 16'h001D, "fault level");
        rc(5'h06, 16'h001D, "fault held");
        evs = 6'h00;
        rc(5'h06, 16'h001D, "fault last");
        rc(5'h06, 16'h000D, "fault gone");
        ev(6'h20);
        rc(5'h06, 16'h0004, "restart");
    endtask

    // Written fields reach the readback and the outgoing word.
    task automatic t_wr7();
        logic [15:0] pat [3];
        pat = '{16'hFFFF, 16'h7D55, 16'h9AAA};
        for (int i = 0; i < 3; i++) begin
            sta.wr(5'h07, pat[i], 1'b1);
            rc(5'h07, pat[i] & 16'hB7FF, "np read");
            chk("np out", np_tx_word, pat[i] & 16'hB7FF);
        end
        chk("np ready", {15'h0000, np_word_ready}, 16'h0001);
    endtask

    // Base page, gating by partner ability and toggling pages.
    task automatic t_np();
        rx_np_bit = 1'b0;
        base_bit11 = 1'b0;
        sta.wr(5'h07, 16'h8123, 1'b0);
        ev(6'h02);
        repeat (3) @(posedge core_clk);
        #1;
        chk("gate off", {14'h0, np_phase_active, np_tx_allowed}, 16'h0);
        chk("first toggle", np_tx_word, 16'h8923);
        rx_np_bit = 1'b1;
        ev(6'h04);
        repeat (3) @(posedge core_clk);
        #1;
        chk("gate on", {14'h0, np_phase_active, np_tx_allowed}, 16'h3);
        tgl = 1'b1;
        for (int i = 0; i < 2; i++) begin
            ev(6'h01);
            tgl = ~tgl;
            rc(5'h07, {4'h8, tgl, 11'h123}, "toggle");
        end
        sta.wr(5'h07, 16'h0123, 1'b0);
        ev(6'h01);
        repeat (3) @(posedge core_clk);
        #1;
        chk("last page", {15'h0000, np_phase_active}, 16'h0000);
        chk("ready gone", {15'h0000, np_word_ready}, 16'h0000);
    endtask

    // ====================
    // Sequence and watchdog
    // ====================
    // Reset for four cycles, then every scenario in turn.
    initial begin
        errors = 0;
        checks = 0;
        reset_n = 1'b0;
        evs = 6'h00;
        cmd_override_we = 1'b0;
        rx_np_bit = 1'b0;
        base_bit11 = 1'b0;
        tgl = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        t_reset();
        t_rsv();
        t_flags();
        t_wr7();
        t_np();
        print_verdict();
    end

    // Cuts a hang short well after the expected run of some 75 cycles.
    initial begin
        repeat (2000) @(posedge core_clk);
        errors++;
        print_verdict();
    end
endmodule

bind anxnp_regs anxnp_regs_chk #(.LOCAL_NP_ABLE(LOCAL_NP_ABLE)) chk_i (
    .core_clk, .reset_n, .mgmt_rd_stb, .mgmt_wr_stb, .mgmt_addr,
    .mgmt_wdata, .mgmt_rdata, .mgmt_rd_valid, .mgmt_rd_hit,
    .cmd_override_we, .exp_aux_bits, .an_restart, .pd_fault_cond,
    .rx_page_stored, .rx_np_bit, .base_page_sent, .base_bit11,
    .np_word_sent, .np_tx_word, .np_tx_allowed, .np_phase_active
);
`default_nettype wire
